//--- design/trig_filter.sv
// measures trigger low time; flags valid pulses and over-long lows
`timescale 1ns/1ps
`default_nettype none
module trig_filter #(
    parameter int MIN_CYC = wdt_pkg::TRIG_MIN_CYC,
    parameter int MAX_CYC = wdt_pkg::TRIG_MAX_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_en,
    input wire logic trigger_input,
    trig_if.filt t
);
    typedef struct packed {
        logic [wdt_pkg::CNT_W-1:0] low_cnt;
        logic prev;
        logic ok;
        logic err;
    } filt_state_t;
    filt_state_t s_r;
    filt_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ok = 1'b0;
        s_nxt.prev = trigger_input;
        if (!trigger_input) begin
            if (s_r.low_cnt <= wdt_pkg::CNT_W'(MAX_CYC)) begin
                s_nxt.low_cnt = s_r.low_cnt + 1'b1;
            end
            if (s_r.low_cnt >= wdt_pkg::CNT_W'(MAX_CYC)) begin
                s_nxt.err = 1'b1;
            end
        end else begin
            s_nxt.low_cnt = '0;
            s_nxt.err = 1'b0;
            // rising edge ends a pulse; a valid one lies in the allowed band
            if (!s_r.prev && s_r.low_cnt >= wdt_pkg::CNT_W'(MIN_CYC)
                    && s_r.low_cnt <= wdt_pkg::CNT_W'(MAX_CYC)) begin
                s_nxt.ok = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_r <= '{low_cnt: '0, prev: 1'b1, ok: 1'b0, err: 1'b0};
        end else if (clock_en) begin
            s_r <= s_nxt;
        end
    end

    assign t.pulse_ok = s_r.ok;
    assign t.low_error = s_r.err;
    assign t.low_now = !s_r.prev;
endmodule : trig_filter
`default_nettype wire

//--- design/trig_if.sv
// trigger pulse qualification signals between filter and supervisor
`timescale 1ns/1ps
`default_nettype none
interface trig_if;
    logic pulse_ok;
    logic low_error;
    logic low_now;
    modport filt (output pulse_ok, output low_error, output low_now);
    modport sup (input pulse_ok, input low_error, input low_now);
endinterface : trig_if
`default_nettype wire

//--- design/wdt_pkg.sv
// constants and types shared by the window watchdog files
package wdt_pkg;
    localparam int CLOCK_MHZ = 200;
    // times in microseconds as printed or chosen
    localparam int TRIG_MIN_US = 10;
    localparam int TRIG_MAX_US = 5000;
    localparam int SYNC_TIMEOUT_US = 20000;
    localparam int SHORT_CLOSED_US = 1000;
    localparam int SHORT_OPEN_US = 1000;
    localparam int LONG_CLOSED_US = 10000;
    localparam int LONG_OPEN_US = 10000;
    localparam int RESET_EXT_US = 2000;
    // cycle counts; each time is multiplied by CLOCK_MHZ, exact with no rounding
    localparam int TRIG_MIN_CYC = TRIG_MIN_US * CLOCK_MHZ;
    localparam int TRIG_MAX_CYC = TRIG_MAX_US * CLOCK_MHZ;
    localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_US * CLOCK_MHZ;
    localparam int SHORT_CLOSED_CYC = SHORT_CLOSED_US * CLOCK_MHZ;
    localparam int SHORT_OPEN_CYC = SHORT_OPEN_US * CLOCK_MHZ;
    localparam int LONG_CLOSED_CYC = LONG_CLOSED_US * CLOCK_MHZ;
    localparam int LONG_OPEN_CYC = LONG_OPEN_US * CLOCK_MHZ;
    localparam int RESET_EXT_CYC = RESET_EXT_US * CLOCK_MHZ;
    localparam int CNT_W = 24;
    typedef enum logic [1:0] {
        ST_SYNC = 2'b00,
        ST_CLOSED = 2'b01,
        ST_OPEN = 2'b11,
        ST_RESET = 2'b10
    } wd_state_t;
endpackage : wdt_pkg

//--- design/window_watchdog.sv
// window watchdog supervising a host trigger and driving its reset line
`timescale 1ns/1ps
`default_nettype none
module window_watchdog #(
    parameter int SYNC_CYC = wdt_pkg::SYNC_TIMEOUT_CYC,
    parameter int S_CLOSED_CYC = wdt_pkg::SHORT_CLOSED_CYC,
    parameter int S_OPEN_CYC = wdt_pkg::SHORT_OPEN_CYC,
    parameter int L_CLOSED_CYC = wdt_pkg::LONG_CLOSED_CYC,
    parameter int L_OPEN_CYC = wdt_pkg::LONG_OPEN_CYC,
    parameter int EXT_CYC = wdt_pkg::RESET_EXT_CYC,
    parameter int TRIG_MIN = wdt_pkg::TRIG_MIN_CYC,
    parameter int TRIG_MAX = wdt_pkg::TRIG_MAX_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_en,
    input wire logic supervisor_off_n,
    input wire logic long_mode,
    input wire logic trigger_input,
    output logic reset_output_n,
    output logic trigger_error
);
    localparam int W = wdt_pkg::CNT_W;

    typedef struct packed {
        wdt_pkg::wd_state_t st;
        logic [W-1:0] cnt;
        logic rst_n;
        logic err;
    } wd_t;
    wd_t s_r;
    wd_t s_nxt;

    trig_if t ();

    trig_filter #(
        .MIN_CYC(TRIG_MIN),
        .MAX_CYC(TRIG_MAX)
    ) u_filter (
        .clock(clock),
        .reset(reset),
        .clock_en(clock_en),
        .trigger_input(trigger_input),
        .t(t.filt)
    );

    function automatic logic [W-1:0] closed_len(input logic lng);
        closed_len = lng ? W'(L_CLOSED_CYC) : W'(S_CLOSED_CYC);
    endfunction : closed_len

    function automatic logic [W-1:0] open_len(input logic lng);
        open_len = lng ? W'(L_OPEN_CYC) : W'(S_OPEN_CYC);
    endfunction : open_len

    always_comb begin
        s_nxt = s_r;
        s_nxt.err = t.low_error;
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (!supervisor_off_n) begin
            // disabled: released, and parked in sync for re-enable
            s_nxt.st = wdt_pkg::ST_SYNC;
            s_nxt.cnt = '0;
            s_nxt.rst_n = 1'b1;
            s_nxt.err = 1'b0;
        end else begin
            unique case (s_r.st)
                wdt_pkg::ST_SYNC: begin
                    if (t.pulse_ok) begin
                        s_nxt.st = wdt_pkg::ST_CLOSED;
                        s_nxt.cnt = '0;
                    end else if (s_r.cnt >= W'(SYNC_CYC - 1)) begin
                        s_nxt.st = wdt_pkg::ST_RESET;
                        s_nxt.cnt = '0;
                    end
                end
                wdt_pkg::ST_CLOSED: begin
                    if (t.pulse_ok) begin
                        s_nxt.st = wdt_pkg::ST_RESET;
                        s_nxt.cnt = '0;
                    end else if (s_r.cnt >= closed_len(long_mode) - 1'b1) begin
                        s_nxt.st = wdt_pkg::ST_OPEN;
                        s_nxt.cnt = '0;
                    end
                end
                wdt_pkg::ST_OPEN: begin
                    if (t.pulse_ok) begin
                        s_nxt.st = wdt_pkg::ST_CLOSED;
                        s_nxt.cnt = '0;
                    end else if (s_r.cnt >= open_len(long_mode) - 1'b1) begin
                        s_nxt.st = wdt_pkg::ST_RESET;
                        s_nxt.cnt = '0;
                    end
                end
                wdt_pkg::ST_RESET: begin
                    // a trigger pulse during reset stretches it by restarting
                    if (t.pulse_ok || t.low_now) begin
                        s_nxt.cnt = '0;
                    end else if (s_r.cnt >= W'(EXT_CYC - 1)) begin
                        s_nxt.st = wdt_pkg::ST_SYNC;
                        s_nxt.cnt = '0;
                    end
                end
            endcase
            s_nxt.rst_n = !(s_nxt.st == wdt_pkg::ST_RESET || t.low_error);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_r <= '{st: wdt_pkg::ST_SYNC, cnt: '0, rst_n: 1'b1, err: 1'b0};
        end else if (clock_en) begin
            s_r <= s_nxt;
        end
    end

    assign reset_output_n = s_r.rst_n;
    assign trigger_error = s_r.err;
endmodule : window_watchdog
`default_nettype wire

//--- tb/host_model.sv
// host model driving the trigger line with low pulses
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clock,
    output var logic trigger_input
);
    initial trigger_input = 1'b1;
    task automatic pulse(input int n);
        trigger_input = 1'b0;
        repeat (n) @(posedge clock);
        #1 trigger_input = 1'b1;
    endtask : pulse
endmodule : host_model
`default_nettype wire

//--- tb/window_watchdog_asserts.sv
// port checker for the window watchdog
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_asserts #(parameter int TMAX = 20, parameter int SYNC = 200,
    parameter int EXT = 40) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_en,
    input wire logic supervisor_off_n,
    input wire logic long_mode,
    input wire logic trigger_input,
    input wire logic reset_output_n,
    input wire logic trigger_error
);
    logic [15:0] low_r, hi_r, rlo_r;
    always_ff @(posedge clock) begin
        low_r <= (reset || trigger_input) ? 16'h0 : low_r + 16'h1;
        hi_r <= (reset || !supervisor_off_n || !trigger_input || !reset_output_n) ? 16'h0
            : hi_r + 16'h1;
        rlo_r <= (reset || trigger_error || !trigger_input || reset_output_n) ? 16'h0
            : rlo_r + 16'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    property p_off; !supervisor_off_n [*2] |-> reset_output_n; endproperty
    a_off: assert property (p_off) else $error("reset out low while off");
    property p_on; $rose(supervisor_off_n) && !trigger_error |-> reset_output_n; endproperty
    a_on: assert property (p_on) else $error("reset out low on enable");
    property p_err_late; $rose(trigger_error) |-> low_r >= TMAX; endproperty
    a_err_late: assert property (p_err_late) else $error("error too early");
    property p_err_due; supervisor_off_n && low_r > TMAX + 3 |-> trigger_error; endproperty
    a_err_due: assert property (p_err_due) else $error("error missing");
    property p_err_clr; trigger_input [*3] |-> !trigger_error; endproperty
    a_err_clr: assert property (p_err_clr) else $error("error after rise");
    property p_err_rst; (supervisor_off_n && trigger_error) [*2] |-> !reset_output_n; endproperty
    a_err_rst: assert property (p_err_rst) else $error("reset out high in error");
    property p_sync; supervisor_off_n |-> hi_r <= SYNC + 4; endproperty
    a_sync: assert property (p_sync) else $error("no reset on missing trigger");
    property p_ext; rlo_r <= EXT + 4; endproperty
    a_ext: assert property (p_ext) else $error("reset out low too long");
endmodule : window_watchdog_asserts
bind window_watchdog window_watchdog_asserts #(.TMAX(TRIG_MAX), .SYNC(SYNC_CYC),
    .EXT(EXT_CYC)) window_watchdog_asserts_inst (.clock(clock), .reset(reset),
    .clock_en(clock_en), .supervisor_off_n(supervisor_off_n), .long_mode(long_mode),
    .trigger_input(trigger_input), .reset_output_n(reset_output_n),
    .trigger_error(trigger_error));
`default_nettype wire

//--- tb/window_watchdog_bench.sv
// self-checking bench for the window watchdog
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_bench;
    localparam int EXT = 40;
    localparam int SYNC = 200;
    localparam int S_CL = 50;
    localparam int S_OP = 50;
    localparam int L_CL = 100;
    localparam int L_OP = 100;
    localparam int T_MIN = 4;
    localparam int T_MAX = 20;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clock_en = 1'b1;
    logic supervisor_off_n = 1'b1;
    logic long_mode = 1'b0;
    wire logic trigger_input;
    logic reset_output_n, trigger_error;
    int n_mismatch = 0;
    int num_checks = 0;
    int n;
    window_watchdog #(.SYNC_CYC(SYNC), .S_CLOSED_CYC(S_CL), .S_OPEN_CYC(S_OP),
        .L_CLOSED_CYC(L_CL), .L_OPEN_CYC(L_OP), .EXT_CYC(EXT), .TRIG_MIN(T_MIN),
        .TRIG_MAX(T_MAX)) window_watchdog_inst (
        .clock(clock), .reset(reset), .clock_en(clock_en), .supervisor_off_n(supervisor_off_n),
        .long_mode(long_mode), .trigger_input(trigger_input), .reset_output_n(reset_output_n),
        .trigger_error(trigger_error));
    host_model host_model_inst (.clock(clock), .trigger_input(trigger_input));
    initial forever #2.5 clock = ~clock;
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : cyc
    task automatic check(input string what, input int lo, input int hi, input int got);
        num_checks++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : check
    task automatic wait_lvl(input logic v, input int max, output int k);
        k = 0;
        while (reset_output_n !== v && k < max) begin
            cyc(1);
            k++;
        end
    endtask : wait_lvl
    task automatic t_window(input logic lm, input int len);
        long_mode = lm;
        host_model_inst.pulse(8);
        cyc(lm ? L_CL + 10 : S_CL + 10);
        host_model_inst.pulse(8);
        wait_lvl(1'b0, len + 10, n);
        check("window trigger", len, len + 4, n);
        wait_lvl(1'b1, EXT + 10, n);
        check("window reset", EXT - 2, EXT + 3, n);
    endtask : t_window
    task automatic t_closed;
        host_model_inst.pulse(8);
        cyc(10);
        host_model_inst.pulse(8);
        wait_lvl(1'b0, 5, n);
        check("closed trigger", 1, 3, n);
        cyc(10);
        host_model_inst.pulse(10);
        wait_lvl(1'b1, EXT + 10, n);
        check("extended reset", EXT - 2, EXT + 3, n);
    endtask : t_closed
    task automatic t_error;
        fork
            host_model_inst.pulse(30);
            begin
                cyc(26);
                check("trigger error", 1, 1, int'(trigger_error === 1'b1));
                check("reset in error", 1, 1, int'(reset_output_n === 1'b0));
            end
        join
        cyc(3);
        check("error cleared", 1, 1, int'(trigger_error === 1'b0));
        wait_lvl(1'b1, EXT + 10, n);
    endtask : t_error
    task automatic t_off;
        supervisor_off_n = 1'b0;
        cyc(SYNC + 20);
        check("off released", 1, 1, int'(reset_output_n === 1'b1));
        supervisor_off_n = 1'b1;
        wait_lvl(1'b0, SYNC + 10, n);
        check("resync timeout", SYNC - 3, SYNC + 4, n);
    endtask : t_off
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        #20000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        cyc(12);
        reset = 1'b0;
        wait_lvl(1'b0, SYNC + 10, n);
        check("sync timeout", SYNC - 3, SYNC + 4, n);
        wait_lvl(1'b1, EXT + 10, n);
        check("reset length", EXT - 2, EXT + 3, n);
        t_window(1'b0, S_CL + S_OP);
        t_closed();
        t_window(1'b1, L_CL + L_OP);
        wait_lvl(1'b1, EXT + 10, n);
        long_mode = 1'b0;
        t_error();
        t_off();
        complete_run();
    end
endmodule : window_watchdog_bench
`default_nettype wire
